// ---- core/mas_top.sv ----
//Contract
// - soft limit reached: 67h, excitation on, clearable
// - limit sensor during home offset: 6Ah, 7 blinks
// - mixed direction or five links: 70h
// - positioning start at zero speed: 70h
// - push speed above 30 r/min: 70h
// - bad gear resolution: 71h, off, power-cycle only
// - wrap inconsistent with resolution: 72h, off, power-cycle
// - network lost while running: 81h, on, clearable
// - rate switch out of range: 83h, off, uncleared
// - excitation-off alarm cuts current, engages brake
// - excitation-on alarm keeps current, holds position
// - position-clear-only alarms ignore alarm clear input
// - limit sensor with hardware overtravel: 66h
`include "mas_consts.svh"

module mas_top
	import mas_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic forward_limit_sensor_i,
	input wire logic reverse_limit_sensor_i,
	input wire logic alarm_clear_input_i,
	input wire logic position_clear_input_i,
	input wire logic [3:0] rate_select_switch_i,
	input wire logic net_disconn_i,
	input wire logic signed [31:0] cmd_pos_i,
	input wire logic homing_offset_i,
	input wire logic motor_busy_i,
	input wire mas_start_t start_i,
	output logic start_ack_o,
	output logic start_rej_o,
	output mas_alarm_t alarm_o,
	output logic excite_en_o,
	output logic brake_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [8:0] pins_s;
	logic fls_s;
	logic rls_s;
	logic aclr_s;
	logic pclr_s;
	logic [3:0] rate_s;
	logic net_s;
	logic aclr_d1_q;
	logic pclr_d1_q;
	logic aclr_rise;
	logic pclr_rise;

	mas_sync #(
		.W(9)
	) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.d_i({net_disconn_i, rate_select_switch_i, position_clear_input_i,
			alarm_clear_input_i, reverse_limit_sensor_i,
			forward_limit_sensor_i}),
		.q_o(pins_s)
	);

	assign {net_s, rate_s, pclr_s, aclr_s, rls_s, fls_s} = pins_s;

	// rising edges of the two clear inputs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aclr_d1_q <= 1'b0;
			pclr_d1_q <= 1'b0;
		end else begin
			aclr_d1_q <= aclr_s;
			pclr_d1_q <= pclr_s;
		end
	end

	assign aclr_rise = aclr_s & ~aclr_d1_q;
	assign pclr_rise = pclr_s & ~pclr_d1_q;

	////////////////////////////////////////////////////////////////////
	// register file over avalon-mm

	logic [3:0] ctrl_q;
	logic [7:0] pclr_only_q;
	logic signed [31:0] plim_q;
	logic signed [31:0] nlim_q;
	logic [31:0] gear_q;
	logic [31:0] wrap_q;
	logic [7:0] stat_q;
	logic [7:0] mask_q;
	logic wait_q;
	logic wr_go;
	logic [7:0] cause;

	assign wr_go = avs_write_i & ~wait_q;

	// one wait cycle per access, then release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_q <= 1'b1;
		end else if (!wait_q) begin
			wait_q <= 1'b1;
		end else if (avs_read_i | avs_write_i) begin
			wait_q <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= `MAS_CTRL_RST;
			pclr_only_q <= `MAS_SRC_ZERO;
			plim_q <= `MAS_PLIM_RST;
			nlim_q <= `MAS_NLIM_RST;
			gear_q <= `MAS_RES_RST;
			wrap_q <= `MAS_RES_RST;
			mask_q <= `MAS_SRC_ZERO;
		end else if (wr_go) begin
			case (avs_address_i)
				`MAS_A_CTRL: ctrl_q <= avs_writedata_i[3:0];
				`MAS_A_PCLR: pclr_only_q <= avs_writedata_i[7:0];
				`MAS_A_PLIM: plim_q <= avs_writedata_i;
				`MAS_A_NLIM: nlim_q <= avs_writedata_i;
				`MAS_A_GEAR: gear_q <= avs_writedata_i;
				`MAS_A_WRAP: wrap_q <= avs_writedata_i;
				`MAS_A_MASK: mask_q <= avs_writedata_i[7:0];
				default: ;
			endcase
		end
	end

	// sticky status, write one to clear, a new cause wins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_q <= `MAS_SRC_ZERO;
		end else if (wr_go && avs_address_i == `MAS_A_STAT) begin
			stat_q <= (stat_q & ~avs_writedata_i[7:0]) | cause;
		end else begin
			stat_q <= stat_q | cause;
		end
	end

	// read data captured on the first request cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_readdata_o <= `MAS_WORD_ZERO;
		end else if (avs_read_i && wait_q) begin
			case (avs_address_i)
				`MAS_A_CTRL: avs_readdata_o <= {28'h0, ctrl_q};
				`MAS_A_PCLR: avs_readdata_o <= {24'h0, pclr_only_q};
				`MAS_A_PLIM: avs_readdata_o <= plim_q;
				`MAS_A_NLIM: avs_readdata_o <= nlim_q;
				`MAS_A_GEAR: avs_readdata_o <= gear_q;
				`MAS_A_WRAP: avs_readdata_o <= wrap_q;
				`MAS_A_STAT: avs_readdata_o <= {24'h0, stat_q};
				`MAS_A_MASK: avs_readdata_o <= {24'h0, mask_q};
				`MAS_A_ALRM: avs_readdata_o <= {18'h0, alarm_o};
				default: avs_readdata_o <= `MAS_WORD_ZERO;
			endcase
		end
	end

	assign avs_waitrequest_o = wait_q;

	////////////////////////////////////////////////////////////////////
	// fault detection

	mas_state_t state_q;
	mas_state_t state_d;
	logic start_ok;
	logic bad_data;
	logic any_ls;

	assign any_ls = fls_s | rls_s;
	assign start_ok = (state_q == mas_st_idle);

	// operation data checks on a start request
	always_comb begin
		bad_data = start_i.dir_mixed;
		if (start_i.link_cnt >= `MAS_LINK_MAX) begin
			bad_data = 1'b1;
		end
		if (start_i.kind == mas_op_position &&
			start_i.speed == `MAS_SPD_ZERO) begin
			bad_data = 1'b1;
		end
		if (start_i.kind == mas_op_push &&
			start_i.speed > `MAS_SPD_PUSH_MAX) begin
			bad_data = 1'b1;
		end
	end

	// present cause of each alarm source
	always_comb begin
		cause = `MAS_SRC_ZERO;
		cause[`MAS_S_HWOT] = ctrl_q[`MAS_C_HWOT] & any_ls;
		cause[`MAS_S_SWOT] = ctrl_q[`MAS_C_SWOT] &
			(cmd_pos_i >= plim_q || cmd_pos_i <= nlim_q);
		cause[`MAS_S_HOFS] = homing_offset_i & any_ls;
		cause[`MAS_S_DATA] = start_i.valid & start_ok & bad_data;
		cause[`MAS_S_GEAR] = gear_q < `MAS_RES_MIN ||
			gear_q > `MAS_RES_MAX;
		cause[`MAS_S_WRAP] = ctrl_q[`MAS_C_WRAP] & (wrap_q < gear_q);
		cause[`MAS_S_NET] = net_s & motor_busy_i;
		cause[`MAS_S_RATE] = rate_s > `MAS_RATE_MAX;
	end

	////////////////////////////////////////////////////////////////////
	// alarm latch

	logic [2:0] src_q;
	logic [2:0] pick;
	logic pick_off;
	logic clr_ok;
	logic load;
	localparam logic [7:0] off_src = `MAS_OFF_MASK; // cut excitation
	localparam logic [7:0] noclr_src = `MAS_NOCLR_MASK; // power-up only
	// pick excitation-off sources first, then lowest index
	always_comb begin
		pick = 3'h0;
		pick_off = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (cause[i] && !off_src[i]) begin
				pick = i[2:0];
			end
		end
		for (int i = 7; i >= 0; i--) begin
			if (cause[i] && off_src[i]) begin
				pick = i[2:0];
				pick_off = 1'b1;
			end
		end
	end

	// a clear needs the right input and the cause to be gone
	always_comb begin
		clr_ok = 1'b0;
		if (state_q != mas_st_idle && !cause[src_q] &&
			!noclr_src[src_q]) begin
			if (pclr_only_q[src_q]) begin
				clr_ok = pclr_rise;
			end else begin
				clr_ok = aclr_rise;
			end
		end
	end

	// state transitions
	always_comb begin
		load = 1'b0;
		state_d = state_q;
		case (state_q)
			mas_st_idle: begin
				if (|cause) begin
					load = 1'b1;
					state_d = pick_off ? mas_st_free : mas_st_hold;
				end
			end
			mas_st_hold: begin
				if (pick_off) begin
					load = 1'b1;
					state_d = mas_st_free;
				end else if (clr_ok) begin
					state_d = mas_st_idle;
				end
			end
			mas_st_free: begin
				if (clr_ok) begin
					state_d = mas_st_idle;
				end
			end
			default: state_d = mas_st_idle;
		endcase
	end

	// state and latched source
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= mas_st_idle;
			src_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (load) begin
				src_q <= pick;
			end
		end
	end

	// code lookup for the alarm report
	function automatic logic [7:0] code_of(input logic [2:0] s);
		case (s)
			3'h0: code_of = `MAS_CODE_HWOT;
			3'h1: code_of = `MAS_CODE_SWOT;
			3'h2: code_of = `MAS_CODE_HOFS;
			3'h3: code_of = `MAS_CODE_DATA;
			3'h4: code_of = `MAS_CODE_GEAR;
			3'h5: code_of = `MAS_CODE_WRAP;
			3'h6: code_of = `MAS_CODE_NET;
			default: code_of = `MAS_CODE_RATE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// outputs, all registered

	// alarm report and drive stage control
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alarm_o <= '0;
			excite_en_o <= 1'b1;
			brake_o <= 1'b0;
		end else begin
			alarm_o.active <= state_d != mas_st_idle;
			alarm_o.excite_off <= state_d == mas_st_free;
			alarm_o.code <= (state_d == mas_st_idle) ? `MAS_CODE_NONE :
				(load ? code_of(pick) : code_of(src_q));
			alarm_o.blinks <= (state_d != mas_st_idle) ? `MAS_BLINKS :
				4'h0;
			excite_en_o <= state_d != mas_st_free;
			brake_o <= (state_d == mas_st_free) &
				ctrl_q[`MAS_C_BRAKE];
		end
	end

	// start answers: accept only with no alarm and clean data
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_ack_o <= 1'b0;
			start_rej_o <= 1'b0;
		end else begin
			start_ack_o <= start_i.valid & start_ok & ~bad_data & ~|cause;
			start_rej_o <= start_i.valid &
				~(start_ok & ~bad_data & ~|cause);
		end
	end

	// interrupt from unmasked sticky status
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_q & mask_q);
		end
	end

endmodule

// ---- core/mas_consts.svh ----
`ifndef MAS_CONSTS_SVH
`define MAS_CONSTS_SVH

// register byte offsets
`define MAS_A_CTRL 6'h00
`define MAS_A_PCLR 6'h04
`define MAS_A_PLIM 6'h08
`define MAS_A_NLIM 6'h0c
`define MAS_A_GEAR 6'h10
`define MAS_A_WRAP 6'h14
`define MAS_A_STAT 6'h18
`define MAS_A_MASK 6'h1c
`define MAS_A_ALRM 6'h20

// control register bit positions
`define MAS_C_HWOT 0
`define MAS_C_SWOT 1
`define MAS_C_BRAKE 2
`define MAS_C_WRAP 3

// alarm source indices, one status bit each
`define MAS_S_HWOT 0
`define MAS_S_SWOT 1
`define MAS_S_HOFS 2
`define MAS_S_DATA 3
`define MAS_S_GEAR 4
`define MAS_S_WRAP 5
`define MAS_S_NET 6
`define MAS_S_RATE 7

// alarm codes
`define MAS_CODE_HWOT 8'h66
`define MAS_CODE_SWOT 8'h67
`define MAS_CODE_HOFS 8'h6a
`define MAS_CODE_DATA 8'h70
`define MAS_CODE_GEAR 8'h71
`define MAS_CODE_WRAP 8'h72
`define MAS_CODE_NET 8'h81
`define MAS_CODE_RATE 8'h83
`define MAS_CODE_NONE 8'h00

// sources that cut excitation / that only power-up clears
`define MAS_OFF_MASK 8'hb0
`define MAS_NOCLR_MASK 8'hb0

// limits and reset values
`define MAS_RES_MIN 32'h0000_00c8
`define MAS_RES_MAX 32'h0003_0d40
`define MAS_RES_RST 32'h0000_03e8
`define MAS_RATE_MAX 4'h4
`define MAS_SPD_ZERO 16'h0000
`define MAS_SPD_PUSH_MAX 16'h001e
`define MAS_LINK_MAX 4'h5
`define MAS_BLINKS 4'h7
`define MAS_CTRL_RST 4'h0
`define MAS_PLIM_RST 32'h7fff_ffff
`define MAS_NLIM_RST 32'h8000_0000
`define MAS_WORD_ZERO 32'h0000_0000
`define MAS_SRC_ZERO 8'h00

`endif

// ---- core/mas_pkg.sv ----
package mas_pkg;

	// kind of motion the sequencer wants to start
	typedef enum logic [1:0] {
		mas_op_position = 2'h0,
		mas_op_push = 2'h1,
		mas_op_cont = 2'h2,
		mas_op_home = 2'h3
	} mas_op_kind_t;

	// start request from the motion sequencer
	typedef struct packed {
		logic valid;
		mas_op_kind_t kind;
		logic [15:0] speed;
		logic [3:0] link_cnt;
		logic dir_mixed;
	} mas_start_t;

	// alarm report towards the drive stage and indicator
	typedef struct packed {
		logic active;
		logic excite_off;
		logic [7:0] code;
		logic [3:0] blinks;
	} mas_alarm_t;

	// supervisor state, one-hot
	typedef enum logic [2:0] {
		mas_st_idle = 3'b001,
		mas_st_hold = 3'b010,
		mas_st_free = 3'b100
	} mas_state_t;

endpackage

// ---- core/mas_sync.sv ----
// two-stage synchroniser for asynchronous pins
module mas_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end

endmodule

// ---- test/mas_top_asserts.sv ----
module mas_top_asserts
	import mas_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic [3:0] rate_select_switch_i,
	input wire mas_start_t start_i,
	input wire logic start_ack_o,
	input wire logic start_rej_o,
	input wire mas_alarm_t alarm_o,
	input wire logic excite_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////
	// drive stage follows the alarm class
	a_off_cut: assert property (
		alarm_o.active && alarm_o.excite_off |-> !excite_en_o)
		else $error("current on during off alarm");
	a_on_hold: assert property (
		alarm_o.active && !alarm_o.excite_off |-> excite_en_o)
		else $error("current lost during on alarm");
	a_off_sticky: assert property (
		alarm_o.active && alarm_o.excite_off |=> alarm_o.active)
		else $error("off alarm cleared");
	a_rate_bad: assert property (
		(rate_select_switch_i > 4'h4) [*5] |-> alarm_o.excite_off)
		else $error("bad rate switch not latched");
	a_code_kept: assert property (
		alarm_o.active |-> alarm_o.blinks == 4'h7 && alarm_o.code inside
		{8'h66, 8'h67, 8'h6a, 8'h70, 8'h71, 8'h72, 8'h81, 8'h83})
		else $error("bad alarm code");
	////////////////
	// start requests
	a_start_busy: assert property (
		start_i.valid && alarm_o.active |=> start_rej_o && !start_ack_o)
		else $error("start taken during alarm");
	a_zero_speed: assert property (
		start_i.valid && start_i.kind == mas_op_position
		&& start_i.speed == 16'h0 |=> start_rej_o)
		else $error("zero speed start taken");
	a_push_fast: assert property (
		start_i.valid && start_i.kind == mas_op_push
		&& start_i.speed > 16'h1e |=> start_rej_o)
		else $error("fast push taken");
	a_link_bad: assert property (
		start_i.valid && start_i.kind == mas_op_position
		&& (start_i.link_cnt > 4'h4 || start_i.dir_mixed) |=> start_rej_o)
		else $error("bad link taken");
	a_bus_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");
	c_off: cover property (alarm_o.active && alarm_o.excite_off);
	c_ack: cover property (start_ack_o);
	c_rej: cover property (start_rej_o && alarm_o.active);
endmodule

// ---- test/mas_seq_model.sv ----
module mas_seq_model
	import mas_pkg::*;
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire mas_start_t req_i,
	output mas_start_t start_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial start_o = '0;
	// one-cycle start pulse; fields scramble while no request stands
	always @(posedge clk_i) begin
		start_o <= go_i ? {1'b1, req_i[22:0]} : {1'b0, ~start_o[22:0]};
	end
endmodule

// ---- test/testbench.sv ----
`include "mas_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mas_pkg::*;
	logic clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [5:0] avs_address_i = '0;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o;
	logic avs_waitrequest_o, start_ack_o, start_rej_o;
	logic excite_en_o, brake_o, irq_o, go = 1'b0;
	logic forward_limit_sensor_i = 1'b0, reverse_limit_sensor_i = 1'b0;
	logic alarm_clear_input_i = 1'b0, position_clear_input_i = 1'b0;
	logic net_disconn_i = 1'b0, homing_offset_i = 1'b0, motor_busy_i = 1'b0;
	logic [3:0] rate_select_switch_i = '0;
	logic signed [31:0] cmd_pos_i = '0;
	logic [31:0] rnd = 32'hcd19486b;
	mas_start_t start_i, req = '0;
	mas_alarm_t alarm_o;
	logic [31:0] rd_q[$];
	logic [1:0] st_q[$];
	int n_errors = 0, compares = 0, cyc = 0;
	mas_start_t bad[4] = '{'{0, mas_op_position, 0, 1, 0},
		'{0, mas_op_push, 16'h1f, 1, 0}, '{0, mas_op_position, 5, 5, 0},
		'{0, mas_op_position, 5, 1, 1}};
	always #25 clk_i = ~clk_i;
	mas_top u_dut (.clk_i, .nrst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
		.forward_limit_sensor_i, .reverse_limit_sensor_i,
		.alarm_clear_input_i, .position_clear_input_i, .rate_select_switch_i,
		.net_disconn_i, .cmd_pos_i, .homing_offset_i, .motor_busy_i, .start_i,
		.start_ack_o, .start_rej_o, .alarm_o, .excite_en_o, .brake_o, .irq_o);
	mas_seq_model u_seq (.clk_i, .go_i(go), .req_i(req), .start_o(start_i));
	////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] al(input logic [7:0] c, input logic f);
		return {18'h0, 1'b1, f, c, 4'h7};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, '0);
	endtask
	task automatic clr(input logic p);
		if (p)
			position_clear_input_i <= 1'b1;
		else
			alarm_clear_input_i <= 1'b1;
		cy(4);
		position_clear_input_i <= 1'b0;
		alarm_clear_input_i <= 1'b0;
		cy(4);
	endtask
	task automatic st(input mas_start_t r, input logic [1:0] e);
		req <= r;
		go <= 1'b1;
		st_q.push_back(e);
		@(posedge clk_i);
		go <= 1'b0;
		cy(3);
	endtask
	////////////////
	// result watcher and run limit
	always @(posedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0)
			chk("rdata", rd_q.pop_front(), avs_readdata_o);
		if (start_ack_o || start_rej_o)
			chk("start", st_q.pop_front(), {start_ack_o, start_rej_o});
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	////////////////
	initial begin
		cy(8);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		rd(`MAS_A_ALRM, 0);
		rd(`MAS_A_GEAR, `MAS_RES_RST);
		rd(6'h3c, 0);
		bus(1'b1, `MAS_A_MASK, 32'h1);
		bus(1'b1, `MAS_A_CTRL, 32'h1);
		forward_limit_sensor_i <= 1'b1;
		cy(6);
		rd(`MAS_A_ALRM, al(8'h66, 0));
		chk("irq", 1, irq_o);
		chk("excite", 1, excite_en_o);
		clr(0);
		rd(`MAS_A_ALRM, al(8'h66, 0));
		forward_limit_sensor_i <= 1'b0;
		clr(0);
		rd(`MAS_A_ALRM, 0);
		bus(1'b1, `MAS_A_STAT, 32'hff);
		rd(`MAS_A_STAT, 0);
		bus(1'b1, `MAS_A_CTRL, 32'h2);
		bus(1'b1, `MAS_A_PLIM, 32'h64);
		bus(1'b1, `MAS_A_PCLR, 32'h2);
		rnd = lfsr(rnd);
		cmd_pos_i <= 32'h64 + {24'h0, rnd[7:0]};
		cy(4);
		rd(`MAS_A_ALRM, al(8'h67, 0));
		st('{0, mas_op_cont, 5, 1, 0}, 2'b01);
		cmd_pos_i <= '0;
		clr(0);
		rd(`MAS_A_ALRM, al(8'h67, 0));
		clr(1);
		rd(`MAS_A_ALRM, 0);
		for (int i = 0; i < 4; i++) begin
			st(bad[i], 2'b01);
			rd(`MAS_A_ALRM, al(8'h70, 0));
			clr(0);
		end
		st('{0, mas_op_push, 16'h1e, 1, 0}, 2'b10);
		motor_busy_i <= 1'b1;
		net_disconn_i <= 1'b1;
		cy(5);
		rd(`MAS_A_ALRM, al(8'h81, 0));
		net_disconn_i <= 1'b0;
		clr(0);
		rd(`MAS_A_ALRM, 0);
		homing_offset_i <= 1'b1;
		reverse_limit_sensor_i <= 1'b1;
		cy(5);
		rd(`MAS_A_ALRM, al(8'h6a, 0));
		homing_offset_i <= 1'b0;
		reverse_limit_sensor_i <= 1'b0;
		// power-cycle-only alarms, each after a fresh reset
		for (int j = 0; j < 3; j++) begin
			nrst_i <= 1'b0;
			rate_select_switch_i <= '0;
			cy(3);
			nrst_i <= 1'b1;
			@(posedge clk_i);
			bus(1'b1, `MAS_A_CTRL, 32'hc);
			if (j == 0)
				bus(1'b1, `MAS_A_GEAR, 32'h64);
			else if (j == 1)
				bus(1'b1, `MAS_A_WRAP, 32'ha);
			else
				rate_select_switch_i <= 4'h5;
			cy(5);
			rd(`MAS_A_ALRM, al(8'h71 + j[7:0] + (j == 2 ? 8'h10 : 8'h0), 1));
			chk("excite", 0, excite_en_o);
			chk("brake", 1, brake_o);
			clr(0);
			rd(`MAS_A_ALRM, al(8'h71 + j[7:0] + (j == 2 ? 8'h10 : 8'h0), 1));
		end
		close_out();
	end
endmodule
bind mas_top mas_top_asserts u_chk (.clk_i, .nrst_i, .avs_read_i,
	.avs_write_i, .avs_waitrequest_o, .rate_select_switch_i, .start_i,
	.start_ack_o, .start_rej_o, .alarm_o, .excite_en_o);
